// >>> rtl/diag_status_alarm_flags.sv
/*
 * diag_status_alarm_flags: status/control byte and alarm/warning flag bytes
 * of the diagnostic page, served over a 2-wire serial slave. Assumes the
 * pins are asynchronous and pass a two-flop synchroniser; measurement and
 * threshold words and meas_valid come from logic on core_clk.
 */
`timescale 1ns/1ps
module diag_status_alarm_flags
   import diag_pkg::*;
#(
   parameter int READY_TIMEOUT = READY_CYCLES
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_o,
   output logic sda_oe_n,
   input wire logic tx_disable_pin,
   input wire logic laser_fault,
   input wire logic sig_det,
   input wire qty_t meas,
   input wire thr_s thr,
   input wire logic meas_valid,
   output logic tx_off
);
   pins_s sync1_ff, sync2_ff;
   pins_s pins_raw;
   logic scl_prev_ff, sda_prev_ff;
   logic soft_dis_ff;
   logic nrdy_ff;
   logic [31:0] pwr_cnt_ff;
   logic [9:0] alarm_ff, warn_ff;
   logic [9:0] nxt_alarm, nxt_warn;
   link_e state_ff;
   logic [7:0] shreg_ff, ptr_ff;
   logic [3:0] bitcnt_ff;
   logic rw_ff, first_ff, oe_n_ff, tx_off_ff;
   logic scl_rise, scl_fall, start_det, stop_det;
   logic [7:0] rd_data, status_byte;

   assign pins_raw = '{scl: scl_in, sda: sda_in, tx_dis: tx_disable_pin, fault: laser_fault, sig_det: sig_det};

   // first stage is read by the second stage only
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         sync1_ff <= '1;
         sync2_ff <= '1;
      end else begin
         sync1_ff <= pins_raw;
         sync2_ff <= sync1_ff;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         scl_prev_ff <= 1'b1;
         sda_prev_ff <= 1'b1;
      end else begin
         scl_prev_ff <= sync2_ff.scl;
         sda_prev_ff <= sync2_ff.sda;
      end
   end

   assign scl_rise = sync2_ff.scl && !scl_prev_ff;
   assign scl_fall = !sync2_ff.scl && scl_prev_ff;
   assign start_det = sync2_ff.scl && scl_prev_ff && sda_prev_ff && !sync2_ff.sda;
   assign stop_det = sync2_ff.scl && scl_prev_ff && !sda_prev_ff && sync2_ff.sda;

   // threshold comparison per monitored quantity
   genvar gi;
   generate
      for (gi = 0; gi < NUM_QTY; gi++) begin : g_cmp
         logic ah, al, wh, wl;
         if (gi == QTY_TEMP) begin : g_signed
            assign ah = $signed(meas[gi]) > $signed(thr.hi_alarm[gi]);
            assign al = $signed(meas[gi]) < $signed(thr.lo_alarm[gi]);
            assign wh = $signed(meas[gi]) > $signed(thr.hi_warn[gi]);
            assign wl = $signed(meas[gi]) < $signed(thr.lo_warn[gi]);
         end else begin : g_unsigned
            assign ah = meas[gi] > thr.hi_alarm[gi];
            assign al = meas[gi] < thr.lo_alarm[gi];
            assign wh = meas[gi] > thr.hi_warn[gi];
            assign wl = meas[gi] < thr.lo_warn[gi];
         end
         // quantity gi owns flag pair (9-2*gi, 8-2*gi): high then low
         assign nxt_alarm[9-2*gi] = ah;
         assign nxt_alarm[8-2*gi] = al;
         assign nxt_warn[9-2*gi] = wh;
         assign nxt_warn[8-2*gi] = wl;
      end
   endgenerate

   // flags are level-following, never written by the host
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         alarm_ff <= '0;
         warn_ff <= '0;
      end else begin
         alarm_ff <= nxt_alarm;
         warn_ff <= nxt_warn;
      end
   end

   // deadline counter: ready is forced once the power-up window expires
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         pwr_cnt_ff <= '0;
      end else if (pwr_cnt_ff < 32'(READY_TIMEOUT)) begin
         pwr_cnt_ff <= pwr_cnt_ff + 32'd1;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         nrdy_ff <= 1'b1;
      end else begin
         nrdy_ff <= !(meas_valid || (pwr_cnt_ff >= 32'(READY_TIMEOUT)));
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         tx_off_ff <= 1'b1;
      end else begin
         tx_off_ff <= soft_dis_ff || sync2_ff.tx_dis;
      end
   end
   assign tx_off = tx_off_ff;

   always_comb begin
      status_byte = BYTE_ZERO;
      status_byte[ST_PIN_BIT] = sync2_ff.tx_dis;
      status_byte[ST_SOFT_BIT] = soft_dis_ff;
      status_byte[ST_FAULT_BIT] = sync2_ff.fault;
      status_byte[ST_SIGDET_BIT] = sync2_ff.sig_det;
      status_byte[ST_NRDY_BIT] = nrdy_ff;
   end

   always_comb begin
      case (ptr_ff)
         OFS_STATUS: rd_data = status_byte;
         OFS_ALM_HI: rd_data = alarm_ff[9:2];
         OFS_ALM_RX: rd_data = {alarm_ff[1:0], 6'h00};
         OFS_WRN_HI: rd_data = warn_ff[9:2];
         OFS_WRN_RX: rd_data = {warn_ff[1:0], 6'h00};
         default: rd_data = BYTE_ZERO;
      endcase
   end

   // only bit 6 of the status byte is writable; everything else drops the data
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         soft_dis_ff <= SOFT_RESET;
      end else if (state_ff == ST_WRITE && scl_fall && bitcnt_ff == 4'd8 && !first_ff
                   && ptr_ff == OFS_STATUS) begin
         soft_dis_ff <= shreg_ff[ST_SOFT_BIT];
      end
   end

   // serial slave: sample on scl rise, change sda on scl fall
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         state_ff <= ST_IDLE;
         shreg_ff <= BYTE_ZERO;
         bitcnt_ff <= '0;
         rw_ff <= 1'b0;
         first_ff <= 1'b0;
         ptr_ff <= PTR_RESET;
         oe_n_ff <= 1'b1;
      end else if (start_det) begin
         state_ff <= ST_ADDR;
         bitcnt_ff <= '0;
         oe_n_ff <= 1'b1;
      end else if (stop_det) begin
         state_ff <= ST_IDLE;
         oe_n_ff <= 1'b1;
      end else begin
         case (state_ff)
            ST_IDLE: begin
               oe_n_ff <= 1'b1;
            end
            ST_ADDR, ST_WRITE: begin
               if (scl_rise && bitcnt_ff < 4'd8) begin
                  shreg_ff <= {shreg_ff[6:0], sync2_ff.sda};
                  bitcnt_ff <= bitcnt_ff + 4'd1;
               end else if (scl_fall && bitcnt_ff == 4'd8) begin
                  bitcnt_ff <= '0;
                  if (state_ff == ST_ADDR) begin
                     if (shreg_ff[7:1] == DEV_ADDR) begin
                        rw_ff <= shreg_ff[0];
                        first_ff <= 1'b1;
                        oe_n_ff <= 1'b0;
                        state_ff <= ST_ACK_ADDR;
                     end else begin
                        state_ff <= ST_IDLE;
                     end
                  end else begin
                     if (first_ff) begin
                        ptr_ff <= shreg_ff;
                        first_ff <= 1'b0;
                     end else begin
                        ptr_ff <= ptr_ff + 8'd1;
                     end
                     oe_n_ff <= 1'b0;
                     state_ff <= ST_ACK_WR;
                  end
               end
            end
            ST_ACK_ADDR: begin
               if (scl_fall) begin
                  if (rw_ff) begin
                     shreg_ff <= rd_data;
                     oe_n_ff <= rd_data[7];
                     bitcnt_ff <= 4'd1;
                     state_ff <= ST_READ;
                  end else begin
                     oe_n_ff <= 1'b1;
                     state_ff <= ST_WRITE;
                  end
               end
            end
            ST_ACK_WR: begin
               if (scl_fall) begin
                  oe_n_ff <= 1'b1;
                  state_ff <= ST_WRITE;
               end
            end
            ST_READ: begin
               if (scl_fall) begin
                  if (bitcnt_ff == 4'd8) begin
                     oe_n_ff <= 1'b1;
                     ptr_ff <= ptr_ff + 8'd1;
                     state_ff <= ST_ACK_RD;
                  end else begin
                     shreg_ff <= {shreg_ff[6:0], 1'b0};
                     oe_n_ff <= shreg_ff[6];
                     bitcnt_ff <= bitcnt_ff + 4'd1;
                  end
               end
            end
            ST_ACK_RD: begin
               // host nack ends the read; the bus then waits for stop
               if (scl_rise && sync2_ff.sda) begin
                  state_ff <= ST_IDLE;
               end else if (scl_fall) begin
                  shreg_ff <= rd_data;
                  oe_n_ff <= rd_data[7];
                  bitcnt_ff <= 4'd1;
                  state_ff <= ST_READ;
               end
            end
            default: begin
               state_ff <= ST_IDLE;
               oe_n_ff <= 1'b1;
            end
         endcase
      end
   end

   assign sda_o = 1'b0;
   assign sda_oe_n = oe_n_ff;

   property p_tx_off_or;
      @(posedge core_clk) disable iff (rst)
      ##1 tx_off == ($past(soft_dis_ff) || $past(sync2_ff.tx_dis));
   endproperty
   a_tx_off_or: assert property (p_tx_off_or) else $error("transmitter off is not the OR of soft bit and pin");

   property p_soft_write_fast;
      @(posedge core_clk) disable iff (rst)
      $rose(soft_dis_ff) |-> ##[1:2] tx_off;
   endproperty
   a_soft_write_fast: assert property (p_soft_write_fast) else $error("soft disable not applied promptly");

   // two edges of synchroniser latency; skip the edges that still see reset values
   property p_pin_mirror;
      @(posedge core_clk) disable iff (rst)
      !$past(rst) && !$past(rst, 2) |-> status_byte[ST_PIN_BIT] == $past(tx_disable_pin, 2);
   endproperty
   a_pin_mirror: assert property (p_pin_mirror) else $error("status pin bit does not mirror pin");

   property p_fault_sigdet;
      @(posedge core_clk) disable iff (rst)
      !$past(rst) && !$past(rst, 2) |-> status_byte[ST_FAULT_BIT] == $past(laser_fault, 2)
         && status_byte[ST_SIGDET_BIT] == $past(sig_det, 2);
   endproperty
   a_fault_sigdet: assert property (p_fault_sigdet) else $error("fault or signal detect status wrong");

   property p_ready_follows_valid;
      @(posedge core_clk) disable iff (rst)
      meas_valid |=> !nrdy_ff;
   endproperty
   a_ready_follows_valid: assert property (p_ready_follows_valid) else $error("not-ready bit stuck with valid data");

   property p_ready_deadline;
      @(posedge core_clk) disable iff (rst)
      (pwr_cnt_ff >= 32'(READY_TIMEOUT)) |=> !nrdy_ff;
   endproperty
   a_ready_deadline: assert property (p_ready_deadline) else $error("not-ready bit past power-up deadline");

   property p_reserved_zero;
      @(posedge core_clk) disable iff (rst)
      status_byte[5:3] == 3'h0 && warn_ff == $past(nxt_warn) ##0 alarm_ff == $past(nxt_alarm);
   endproperty
   a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits or flags mistracked");

   property p_temp_high_alarm;
      @(posedge core_clk) disable iff (rst)
      ($signed(meas[QTY_TEMP]) > $signed(thr.hi_alarm[QTY_TEMP])) ##1 $stable(meas) |-> alarm_ff[9];
   endproperty
   a_temp_high_alarm: assert property (p_temp_high_alarm) else $error("temperature high alarm not set");

   property p_rx_low_warn;
      @(posedge core_clk) disable iff (rst)
      (meas[4] < thr.lo_warn[4]) |=> warn_ff[0];
   endproperty
   a_rx_low_warn: assert property (p_rx_low_warn) else $error("receive power low warning not set");

   property p_no_drive_idle;
      @(posedge core_clk) disable iff (rst)
      (state_ff == ST_IDLE) [*2] |-> sda_oe_n;
   endproperty
   a_no_drive_idle: assert property (p_no_drive_idle) else $error("sda driven while idle");

   property p_foreign_no_ack;
      @(posedge core_clk) disable iff (rst)
      (state_ff == ST_ADDR && scl_fall && bitcnt_ff == 4'd8 && shreg_ff[7:1] != DEV_ADDR) |=> sda_oe_n;
   endproperty
   a_foreign_no_ack: assert property (p_foreign_no_ack) else $error("foreign device address acknowledged");

   property p_soft_only_by_write;
      @(posedge core_clk) disable iff (rst)
      !$stable(soft_dis_ff) |-> $past(state_ff == ST_WRITE && ptr_ff == OFS_STATUS);
   endproperty
   a_soft_only_by_write: assert property (p_soft_only_by_write) else $error("soft bit changed without a write");

   property p_release_for_host_ack;
      @(posedge core_clk) disable iff (rst)
      (state_ff == ST_ACK_RD) |-> sda_oe_n;
   endproperty
   a_release_for_host_ack: assert property (p_release_for_host_ack) else $error("sda held during host ack");
endmodule

// >>> rtl/diag_pkg.sv
/*
 * diag_pkg: constants, types and encodings for the diagnostic status and
 * alarm/warning flag bank. Assumes one 200 MHz core clock, measurement and
 * threshold words produced by logic on that clock, and a host reaching the
 * page over the 2-wire serial management pins.
 */
// Overview of operation
// - status bit 7 reads the synchronised transmitter-off pin level, 1 when asserted.
// - status bit 6 is a host read/write software transmitter-off bit.
// - transmitter is disabled when software bit 6 OR the pin is asserted.
// - status bit 2 reads 1 while a laser fault is present.
// - status bit 1 mirrors signal detect, 1 when asserted.
// - status bit 0 is not-ready, reading 0 once measurements are valid.
// - software command bits take effect well within 100 ms of the write.
// - not-ready bit reaches ready value within 1000 ms after power-up.
// - alarm byte 112 bits 7/6 flag temperature above high / below low alarm.
// - alarm byte 112 bits 5/4 flag supply voltage high / low alarm.
// - alarm byte 112 bits 3/2 flag laser bias high / low alarm.
// - alarm byte 112 bits 1/0 flag transmit power high / low alarm.
// - alarm byte 113 bits 7/6 flag receive power high / low; bits 5..0 zero.
// - warning byte 116 bits 7/6 flag temperature high / low warning.
// - warning byte 116 bits 5/4 flag supply voltage high / low warning.
// - warning byte 116 bits 3/2 flag laser bias high / low warning.
// - warning byte 116 bits 1/0 flag transmit power high / low warning.
// - warning byte 117 bits 7/6 flag receive power high / low; bits 5..0 zero.
// - status/control byte sits at byte 110 of the second device address page.
// - temperature compares as signed 16-bit, 1/256 C steps, like its thresholds.
package diag_pkg;
   localparam logic [6:0] DEV_ADDR = 7'h51;
   localparam logic [7:0] OFS_STATUS = 8'h6E;
   localparam logic [7:0] OFS_ALM_HI = 8'h70;
   localparam logic [7:0] OFS_ALM_RX = 8'h71;
   localparam logic [7:0] OFS_WRN_HI = 8'h74;
   localparam logic [7:0] OFS_WRN_RX = 8'h75;
   localparam int ST_PIN_BIT = 7;
   localparam int ST_SOFT_BIT = 6;
   localparam int ST_FAULT_BIT = 2;
   localparam int ST_SIGDET_BIT = 1;
   localparam int ST_NRDY_BIT = 0;
   localparam logic SOFT_RESET = 1'b0;
   localparam logic [7:0] PTR_RESET = 8'h00;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam int NUM_QTY = 5;
   localparam int QTY_TEMP = 0;
   localparam int CLK_FREQ_HZ = 200_000_000;
   localparam int T_SOFT_MS = 100;
   localparam int T_READY_MS = 1000;
   localparam int SOFT_CYCLES = T_SOFT_MS * (CLK_FREQ_HZ / 1000);
   localparam int READY_CYCLES = T_READY_MS * (CLK_FREQ_HZ / 1000);
   localparam int SYNC_W = 5;
   typedef logic [NUM_QTY-1:0][15:0] qty_t;
   typedef struct packed {
      qty_t hi_alarm;
      qty_t lo_alarm;
      qty_t hi_warn;
      qty_t lo_warn;
   } thr_s;
   typedef struct packed {
      logic scl;
      logic sda;
      logic tx_dis;
      logic fault;
      logic sig_det;
   } pins_s;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_ADDR = 3'b001,
      ST_ACK_ADDR = 3'b010,
      ST_WRITE = 3'b011,
      ST_ACK_WR = 3'b100,
      ST_READ = 3'b101,
      ST_ACK_RD = 3'b110
   } link_e;
endpackage

// >>> sim/diag_host_model.sv
/*
 * diag_host_model: behavioural host on the 2-wire management pins.
 * Assumes the bench resolves the wire with a pull-up and calls these tasks
 * from a process that runs on falling edges of core_clk.
 */
`timescale 1ns/1ps
module diag_host_model #(
   parameter int HALF = 12
) (
   input wire logic core_clk,
   input wire logic sda_line,
   output logic scl,
   output logic sda_low
);
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end
   task automatic tick(input int n);
      repeat (n) @(negedge core_clk);
   endtask
   // start, bit_cycle and the byte tasks leave at the middle of the scl low phase; stop leaves scl high
   task automatic start();
      sda_low = 1'b0;
      tick(HALF / 2);
      scl = 1'b1;
      tick(HALF);
      sda_low = 1'b1;
      tick(HALF);
      scl = 1'b0;
      tick(HALF / 2);
   endtask
   task automatic stop();
      sda_low = 1'b1;
      tick(HALF / 2);
      scl = 1'b1;
      tick(HALF);
      sda_low = 1'b0;
      tick(HALF);
   endtask
   // data changes only mid-low, well after the slave's 2-3 cycle answer delay
   task automatic bit_cycle(input logic b, output logic got);
      sda_low = ~b;
      tick(HALF / 2);
      scl = 1'b1;
      tick(HALF);
      got = sda_line;
      scl = 1'b0;
      tick(HALF / 2);
   endtask
   task automatic send_byte(input logic [7:0] b, output logic acked);
      logic g;
      for (int i = 7; i >= 0; i--) bit_cycle(b[i], g);
      bit_cycle(1'b1, g);
      acked = ~g;
   endtask
   task automatic recv_byte(input logic last, output logic [7:0] b);
      logic g;
      for (int i = 7; i >= 0; i--) bit_cycle(1'b1, b[i]);
      bit_cycle(last, g);
   endtask
endmodule

// >>> sim/diag_status_alarm_flags_bench.sv
/*
 * diag_status_alarm_flags_bench: drives the status and flag bank through
 * the host model and compares bytes read back with values worked out here.
 * Assumes a pull-up on the data wire and a shortened ready timeout.
 */
`timescale 1ns/1ps
`define CHK(name, exp, got) \
   begin \
      checks_done++; \
      if ((got) !== (exp)) begin \
         bad_count++; \
         $display("Error %s expected %h seen %h", name, exp, got); \
      end \
   end
module diag_status_alarm_flags_bench
   import diag_pkg::*;
;
   localparam int READY_T = 10000;
   localparam int LIMIT = 95000;
   localparam int HI_A = 32'h0000_03E8;
   localparam int HI_W = 32'h0000_0384;
   localparam int LO_W = 32'h0000_00C8;
   localparam int LO_A = 32'h0000_0064;
   localparam logic [15:0] VALS [4] = '{16'h03E9, 16'h03E8, 16'h0063, 16'h00C7};
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic tx_disable_pin = 1'b0;
   logic laser_fault = 1'b0;
   logic sig_det = 1'b0;
   logic meas_valid = 1'b0;
   qty_t meas = {NUM_QTY{16'h01F4}};
   thr_s thr;
   logic sda_o, sda_oe_n, tx_off, scl, sda_low, sda_in, ack_foreign;
   logic [7:0] rd [0:5];
   int bad_count = 0;
   int checks_done = 0;
   int cycles = 0;
   // open-drain wire with pull-up: low if either party pulls it
   assign sda_in = ~(sda_low | (~sda_oe_n & ~sda_o));
   always #2.5 core_clk = ~core_clk;
   diag_host_model host (.core_clk(core_clk), .sda_line(sda_in), .scl(scl), .sda_low(sda_low));
   diag_status_alarm_flags #(.READY_TIMEOUT(READY_T)) uut (
      .core_clk(core_clk), .rst(rst), .scl_in(scl), .sda_in(sda_in), .sda_o(sda_o),
      .sda_oe_n(sda_oe_n), .tx_disable_pin(tx_disable_pin), .laser_fault(laser_fault),
      .sig_det(sig_det), .meas(meas), .thr(thr), .meas_valid(meas_valid), .tx_off(tx_off));
   task automatic print_verdict();
      $display("checks_done %0d bad_count %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic reg_write(input logic [7:0] ofs, input logic [7:0] d);
      logic a0, a1, a2;
      host.start();
      host.send_byte({DEV_ADDR, 1'b0}, a0);
      host.send_byte(ofs, a1);
      host.send_byte(d, a2);
      host.stop();
      `CHK("write acks", 3'b111, {a0, a1, a2});
   endtask
   task automatic reg_read(input logic [7:0] ofs, input int n);
      logic a0, a1, a2;
      host.start();
      host.send_byte({DEV_ADDR, 1'b0}, a0);
      host.send_byte(ofs, a1);
      host.start();
      host.send_byte({DEV_ADDR, 1'b1}, a2);
      for (int i = 0; i < n; i++) host.recv_byte(i == n - 1, rd[i]);
      host.stop();
      `CHK("read acks", 3'b111, {a0, a1, a2});
   endtask
   task automatic chk_status(input logic [7:0] exp);
      reg_read(OFS_STATUS, 1);
      `CHK("status byte", exp, rd[0]);
   endtask
   task automatic chk_flags(input int q, input logic [15:0] v);
      logic [16:0] sv;
      logic [15:0] al, wr;
      meas = {NUM_QTY{16'h01F4}};
      meas[q] = v;
      // temperature is signed, the other quantities are not
      sv = (q == QTY_TEMP) ? {v[15], v} : {1'b0, v};
      al = 16'h0000;
      wr = 16'h0000;
      al[15 - 2 * q] = $signed(sv) > HI_A;
      al[14 - 2 * q] = $signed(sv) < LO_A;
      wr[15 - 2 * q] = $signed(sv) > HI_W;
      wr[14 - 2 * q] = $signed(sv) < LO_W;
      repeat (4) @(negedge core_clk);
      reg_read(OFS_ALM_HI, 6);
      `CHK("alarm bytes", al, {rd[0], rd[1]});
      `CHK("gap bytes", 16'h0000, {rd[2], rd[3]});
      `CHK("warning bytes", wr, {rd[4], rd[5]});
   endtask
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == LIMIT) begin
         bad_count++;
         $display("Error run length expected below %0d seen %0d", LIMIT, cycles);
         print_verdict();
      end
   end
   initial begin
      thr.hi_alarm = {NUM_QTY{16'h03E8}};
      thr.hi_warn = {NUM_QTY{16'h0384}};
      thr.lo_warn = {NUM_QTY{16'h00C8}};
      thr.lo_alarm = {NUM_QTY{16'h0064}};
      repeat (4) @(negedge core_clk);
      rst = 1'b0;
      repeat (4) @(negedge core_clk);
      `CHK("tx_off idle", 1'b0, tx_off);
      chk_status(8'h01);
      tx_disable_pin = 1'b1;
      repeat (4) @(negedge core_clk);
      `CHK("tx_off from pin", 1'b1, tx_off);
      chk_status(8'h81);
      tx_disable_pin = 1'b0;
      reg_write(OFS_STATUS, 8'hFF);
      repeat (2) @(negedge core_clk);
      `CHK("tx_off from soft bit", 1'b1, tx_off);
      laser_fault = 1'b1;
      sig_det = 1'b1;
      chk_status(8'h47);
      reg_write(OFS_STATUS, 8'h00);
      repeat (2) @(negedge core_clk);
      `CHK("tx_off soft cleared", 1'b0, tx_off);
      host.start();
      host.send_byte(8'hA0, ack_foreign);
      host.stop();
      `CHK("foreign address ack", 1'b0, ack_foreign);
      // no valid flag: only the power-up timeout can clear not-ready
      repeat (READY_T) @(negedge core_clk);
      chk_status(8'h06);
      rst = 1'b1;
      repeat (4) @(negedge core_clk);
      rst = 1'b0;
      meas_valid = 1'b1;
      repeat (4) @(negedge core_clk);
      chk_status(8'h06);
      reg_write(OFS_ALM_HI, 8'hFF);
      for (int q = 0; q < NUM_QTY; q++) begin
         for (int k = 0; k < 4; k++) begin
            chk_flags(q, VALS[k]);
         end
      end
      chk_flags(QTY_TEMP, 16'hFFFB);
      print_verdict();
   end
endmodule
